// file: pkg/scg_pkg.sv
package scg_pkg;
    // coefficient and data word geometry
    localparam int COEF_W = 24;
    localparam int DATA_W = 24;
    localparam int PROD_W = 48;
    // gain of 1.0 is 2^22, so the full positive range reaches just under 2x
    localparam int GAIN_FRAC = 22;
    // serial frame length for one coefficient transfer
    localparam int SER_BITS = 24;
    localparam int SER_CNT_W = 5;
    localparam logic [SER_CNT_W-1:0] SER_CNT_FULL = 5'h18;
    localparam logic [SER_CNT_W-1:0] SER_CNT_OVER = 5'h19;
    // result buffer
    localparam int FIFO_DEPTH = 32;
    // reset values
    localparam logic [COEF_W-1:0] GAIN_RESET = 24'h00_0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 24'h00_0000;
    // rounding constant: half of the dropped fraction
    localparam logic signed [PROD_W-1:0] GAIN_ROUND = 48'h0000_0020_0000;
    // saturation limits of the result word
    localparam logic signed [PROD_W-1:0] SAT_MAX = 48'h0000_007F_FFFF;
    localparam logic signed [PROD_W-1:0] SAT_MIN = 48'hFFFF_FF80_0000;
endpackage

// file: pkg/scg_stream_if.sv
`timescale 1ns/1ps
interface scg_stream_if #(parameter int W = 24);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    // producer side
    modport src (output valid, output data, input ready);
    // consumer side
    modport snk (input valid, input data, output ready);
endinterface

// file: hdl/scg_fifo.sv
`timescale 1ns/1ps
module scg_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    scg_stream_if.snk in_s,
    // draining side
    scg_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = DEPTH[AW:0];

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic not_full_reg;
    logic push;
    logic pop;

    // ready is a flop so the source sees honest back-pressure
    assign in_s.ready = not_full_reg;
    assign out_s.valid = (count_reg != '0);
    assign out_s.data = mem[rd_ptr_reg];
    assign push = in_s.valid && not_full_reg;
    assign pop = out_s.valid && out_s.ready;

    // storage write, no reset needed on the array
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_s.data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            not_full_reg <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
                not_full_reg <= (count_reg != CNT_FULL - 1'b1);
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
                not_full_reg <= 1'b1;
            end
        end
    end
endmodule

// file: hdl/scg_shift.sv
`timescale 1ns/1ps
module scg_shift
    import scg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial frame from the host
    input wire logic frame,
    input wire logic shift,
    input wire logic wr,
    input wire logic din,
    output logic dout,
    // register side
    input wire logic [COEF_W-1:0] load_value,
    output logic wr_pulse,
    output logic [COEF_W-1:0] wr_value
);
    logic frame_d_reg;
    logic [COEF_W-1:0] shadow_reg;
    logic [SER_CNT_W-1:0] count_reg;
    logic wr_reg;
    logic frame_rise;
    logic frame_fall;

    assign frame_rise = frame && !frame_d_reg;
    assign frame_fall = !frame && frame_d_reg;

    // frame edge tracking
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_d_reg <= 1'b0;
        end else begin
            frame_d_reg <= frame;
        end
    end

    // shadow snapshots the coefficient at frame start so a read is never torn
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shadow_reg <= GAIN_RESET;
            count_reg <= '0;
            dout <= 1'b0;
            wr_reg <= 1'b0;
        end else if (frame_rise) begin
            shadow_reg <= load_value;
            dout <= load_value[COEF_W-1];
            count_reg <= '0;
            wr_reg <= wr;
        end else if (frame && shift) begin
            shadow_reg <= {shadow_reg[COEF_W-2:0], din};
            dout <= shadow_reg[COEF_W-2];
            if (count_reg != SER_CNT_OVER) begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    // commit only a write frame of exactly one full word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pulse <= 1'b0;
            wr_value <= GAIN_RESET;
        end else begin
            wr_pulse <= frame_fall && wr_reg && (count_reg == SER_CNT_FULL);
            if (frame_fall) begin
                wr_value <= shadow_reg;
            end
        end
    end
endmodule

// file: hdl/scg_top.sv
`timescale 1ns/1ps
module scg_top
    import scg_pkg::*;
#(
    parameter int BUF_DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // serial coefficient access
    input wire logic SER_FRAME,
    input wire logic SER_SHIFT,
    input wire logic SER_WRITE,
    input wire logic SER_DIN,
    output logic SER_DOUT,
    output logic SER_WRITE_DONE,
    output logic SER_WRITE_DROPPED,
    // third control register bits
    input wire logic BYPASS_SELF_GAIN_CORRECTION,
    input wire logic BYPASS_SELF_OFFSET_CORRECTION,
    input wire logic BYPASS_SYSTEM_OFFSET_CORRECTION,
    // neighbouring coefficients
    input wire logic [scg_pkg::COEF_W-1:0] SELF_CAL_OFFSET_COEFFICIENT,
    input wire logic [scg_pkg::COEF_W-1:0] SYSTEM_OFFSET_COEFFICIENT,
    // calibration sequencer
    input wire logic CAL_ACTIVE,
    input wire logic CAL_GAIN_LOAD,
    input wire logic [scg_pkg::COEF_W-1:0] CAL_GAIN_VALUE,
    // raw conversion results
    input wire logic RESULT_VALID,
    input wire logic [scg_pkg::DATA_W-1:0] RESULT_DATA,
    output logic RESULT_READY,
    // corrected results
    output logic OUT_VALID,
    output logic [scg_pkg::DATA_W-1:0] OUT_DATA,
    input wire logic OUT_READY,
    // coefficient readback
    output logic [scg_pkg::COEF_W-1:0] SELF_CAL_GAIN_COEFFICIENT
);
    import scg_pkg::*;

    // saturate a wide signed value into the result word
    function automatic logic [DATA_W-1:0] sat_word(input logic signed [PROD_W-1:0] v);
        logic [DATA_W-1:0] r;
        r = v[DATA_W-1:0];
        if (v > SAT_MAX) begin
            r = SAT_MAX[DATA_W-1:0];
        end else if (v < SAT_MIN) begin
            r = SAT_MIN[DATA_W-1:0];
        end
        return r;
    endfunction

    // streams between the pins, the buffer and the correction pipeline
    scg_stream_if #(.W(DATA_W)) raw_s ();
    scg_stream_if #(.W(DATA_W)) buf_s ();

    logic [COEF_W-1:0] gain_reg;
    logic wr_pulse;
    logic [COEF_W-1:0] wr_value;
    logic ser_dout;
    logic advance;

    logic s1_valid_reg;
    logic [DATA_W-1:0] s1_data_reg;
    logic [DATA_W-1:0] s1_data_next;
    logic s2_valid_reg;
    logic [DATA_W-1:0] s2_data_reg;
    logic [DATA_W-1:0] s2_data_next;
    logic [DATA_W-1:0] out_data_next;

    logic signed [PROD_W-1:0] raw_wide;
    logic signed [PROD_W-1:0] self_off_wide;
    logic signed [PROD_W-1:0] s1_wide;
    logic signed [PROD_W-1:0] gain_wide;
    logic signed [PROD_W-1:0] product;
    logic signed [PROD_W-1:0] scaled;
    logic signed [PROD_W-1:0] s2_wide;
    logic signed [PROD_W-1:0] sys_off_wide;

    // pin side of the result buffer
    assign raw_s.valid = RESULT_VALID;
    assign raw_s.data = RESULT_DATA;
    assign RESULT_READY = raw_s.ready;

    // the buffer absorbs results while the consumer stalls the output
    scg_fifo #(
        .W(DATA_W),
        .DEPTH(BUF_DEPTH)
    ) u_fifo (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .in_s(raw_s),
        .out_s(buf_s)
    );

    // serial shifter snapshots the coefficient for reads, collects writes
    scg_shift u_shift (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .frame(SER_FRAME),
        .shift(SER_SHIFT),
        .wr(SER_WRITE),
        .din(SER_DIN),
        .dout(ser_dout),
        .load_value(gain_reg),
        .wr_pulse(wr_pulse),
        .wr_value(wr_value)
    );
    assign SER_DOUT = ser_dout;

    // coefficient register: calibration load outranks any host write
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            gain_reg <= GAIN_RESET;
        end else if (CAL_GAIN_LOAD) begin
            gain_reg <= CAL_GAIN_VALUE;
        end else if (wr_pulse && !CAL_ACTIVE) begin
            gain_reg <= wr_value;
        end
    end
    assign SELF_CAL_GAIN_COEFFICIENT = gain_reg;

    // write outcome flags, one cycle each, after the frame closes
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            SER_WRITE_DONE <= 1'b0;
            SER_WRITE_DROPPED <= 1'b0;
        end else begin
            SER_WRITE_DONE <= wr_pulse && !CAL_ACTIVE && !CAL_GAIN_LOAD;
            SER_WRITE_DROPPED <= wr_pulse && (CAL_ACTIVE || CAL_GAIN_LOAD);
        end
    end

    // every stage moves together; the output holds while the consumer stalls
    assign advance = !OUT_VALID || OUT_READY;
    assign buf_s.ready = advance;

    // stage 1: self offset removal, widened so the subtraction cannot wrap
    always_comb begin
        raw_wide = PROD_W'(signed'(buf_s.data));
        self_off_wide = PROD_W'(signed'(SELF_CAL_OFFSET_COEFFICIENT));
        if (BYPASS_SELF_OFFSET_CORRECTION) begin
            s1_data_next = buf_s.data;
        end else begin
            s1_data_next = sat_word(raw_wide - self_off_wide);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            s1_valid_reg <= 1'b0;
            s1_data_reg <= DATA_RESET;
        end else if (advance) begin
            s1_valid_reg <= buf_s.valid;
            s1_data_reg <= s1_data_next;
        end
    end

    // stage 2: signed gain, 1.0 at 2^22, rounded to nearest before the shift
    // rounding keeps truncation bias out of the residual error
    always_comb begin
        s1_wide = PROD_W'(signed'(s1_data_reg));
        gain_wide = PROD_W'(signed'(gain_reg));
        product = s1_wide * gain_wide;
        scaled = (product + GAIN_ROUND) >>> GAIN_FRAC;
        if (BYPASS_SELF_GAIN_CORRECTION) begin
            s2_data_next = s1_data_reg;
        end else begin
            s2_data_next = sat_word(scaled);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            s2_valid_reg <= 1'b0;
            s2_data_reg <= DATA_RESET;
        end else if (advance) begin
            s2_valid_reg <= s1_valid_reg;
            s2_data_reg <= s2_data_next;
        end
    end

    // stage 3: system offset, after all self correction
    always_comb begin
        s2_wide = PROD_W'(signed'(s2_data_reg));
        sys_off_wide = PROD_W'(signed'(SYSTEM_OFFSET_COEFFICIENT));
        if (BYPASS_SYSTEM_OFFSET_CORRECTION) begin
            out_data_next = s2_data_reg;
        end else begin
            out_data_next = sat_word(s2_wide - sys_off_wide);
        end
    end

    // output register; system gain follows outside this block
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            OUT_VALID <= 1'b0;
            OUT_DATA <= DATA_RESET;
        end else if (advance) begin
            OUT_VALID <= s2_valid_reg;
            OUT_DATA <= out_data_next;
        end
    end
endmodule

// file: verif/scg_props.sv
`timescale 1ns/1ps
module scg_props
    import scg_pkg::*;
(
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    // serial access
    input wire logic SER_FRAME,
    input wire logic SER_WRITE,
    input wire logic SER_DOUT,
    input wire logic SER_WRITE_DONE,
    input wire logic SER_WRITE_DROPPED,
    // calibration
    input wire logic CAL_ACTIVE,
    input wire logic CAL_GAIN_LOAD,
    input wire logic [scg_pkg::COEF_W-1:0] CAL_GAIN_VALUE,
    // output stream and coefficient
    input wire logic OUT_VALID,
    input wire logic OUT_READY,
    input wire logic [scg_pkg::DATA_W-1:0] OUT_DATA,
    input wire logic [scg_pkg::COEF_W-1:0] SELF_CAL_GAIN_COEFFICIENT
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    // steps of a read frame and of a write answer
    sequence s_read_start;
        $rose(SER_FRAME) && !SER_WRITE;
    endsequence
    sequence s_flag_once;
        !(SER_WRITE_DONE && SER_WRITE_DROPPED) ##1 !SER_WRITE_DONE && !SER_WRITE_DROPPED;
    endsequence
    a_reset_clears_coef: assert property (disable iff (1'b0)
        !RESET_N |=> SELF_CAL_GAIN_COEFFICIENT == GAIN_RESET) else $error("coefficient not cleared by reset");
    a_cal_load_whole: assert property (CAL_GAIN_LOAD |=>
        SELF_CAL_GAIN_COEFFICIENT == $past(CAL_GAIN_VALUE)) else $error("calibration load not taken whole");
    a_coef_change_cause: assert property ($changed(SELF_CAL_GAIN_COEFFICIENT) && $past(RESET_N) |->
        $past(CAL_GAIN_LOAD) || SER_WRITE_DONE) else $error("coefficient changed without cause");
    a_done_not_cal: assert property (SER_WRITE_DONE |->
        !$past(CAL_ACTIVE) && !$past(CAL_GAIN_LOAD)) else $error("write committed during calibration");
    a_drop_needs_cal: assert property (SER_WRITE_DROPPED |->
        $past(CAL_ACTIVE) || $past(CAL_GAIN_LOAD)) else $error("write dropped without calibration");
    a_flag_single_pulse: assert property ((SER_WRITE_DONE || SER_WRITE_DROPPED) |-> s_flag_once)
        else $error("write flag not a single pulse");
    // the flag answers the frame end two edges later; a new frame may already have begun
    a_flag_after_frame: assert property ((SER_WRITE_DONE || SER_WRITE_DROPPED) |->
        !$past(SER_FRAME, 2) && $past(SER_FRAME, 3)) else $error("write flag not timed to frame end");
    a_read_msb_first: assert property (s_read_start |=>
        SER_DOUT == $past(SELF_CAL_GAIN_COEFFICIENT[COEF_W-1])) else $error("read does not start with msb");
    a_out_data_hold: assert property (OUT_VALID && !OUT_READY |=>
        OUT_VALID && $stable(OUT_DATA)) else $error("stalled output word changed");
endmodule
bind scg_top scg_props chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .SER_FRAME(SER_FRAME),
    .SER_WRITE(SER_WRITE), .SER_DOUT(SER_DOUT), .SER_WRITE_DONE(SER_WRITE_DONE),
    .SER_WRITE_DROPPED(SER_WRITE_DROPPED), .CAL_ACTIVE(CAL_ACTIVE), .CAL_GAIN_LOAD(CAL_GAIN_LOAD),
    .CAL_GAIN_VALUE(CAL_GAIN_VALUE), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA),
    .SELF_CAL_GAIN_COEFFICIENT(SELF_CAL_GAIN_COEFFICIENT));

// file: verif/scg_host_model.sv
`timescale 1ns/1ps
module scg_host_model (
    // serial lines toward the block
    input wire logic clk,
    output logic frame,
    output logic shift,
    output logic wr,
    output logic din,
    input wire logic dout
);
    initial begin
        frame = 0;
        shift = 0;
        wr = 0;
        din = 0;
    end
    // write frame of nbits bits; a short count lets a scenario send a bad frame
    task automatic wr24(input logic [23:0] v, input int nbits);
        @(negedge clk) begin frame = 1; wr = 1; end
        for (int i = nbits - 1; i >= 0; i--) begin
            @(negedge clk);
            shift = 1;
            din = v[i];
        end
        @(negedge clk);
        shift = 0;
        frame = 0;
        din = ~din; // released line must not keep the last bit
    endtask
    // read frame: bit 23 arrives first, each shift brings the next one
    task automatic rd24(output logic [23:0] v);
        @(negedge clk) begin frame = 1; wr = 0; end
        for (int i = 23; i >= 0; i--) begin
            @(negedge clk);
            v[i] = dout;
            shift = (i != 0);
        end
        @(negedge clk);
        frame = 0;
    endtask
endmodule

// file: verif/self_cal_gain_correction_bench.sv
`timescale 1ns/1ps
module self_cal_gain_correction_bench;
    import scg_pkg::*;
    logic clk = 0, rst_n = 0, frame, shift, wr, din, dout, wdone, wdrop;
    logic bg = 0, bo = 0, bs = 0, ca = 0, cl = 0, rv = 0, rr, ov, ordy = 1;
    logic [23:0] so = 24'h00_0011, sy = 24'hFF_FFF0, cv = 0, rd = 0, od, coef;
    int bad_count = 0, checks_done = 0;
    // clock at 125 MHz
    always #4 clk = ~clk;
    scg_host_model host (.clk(clk), .frame(frame), .shift(shift), .wr(wr), .din(din), .dout(dout));
    scg_top uut (.CORE_CLK(clk), .RESET_N(rst_n), .SER_FRAME(frame), .SER_SHIFT(shift), .SER_WRITE(wr),
        .SER_DIN(din), .SER_DOUT(dout), .SER_WRITE_DONE(wdone), .SER_WRITE_DROPPED(wdrop),
        .BYPASS_SELF_GAIN_CORRECTION(bg), .BYPASS_SELF_OFFSET_CORRECTION(bo),
        .BYPASS_SYSTEM_OFFSET_CORRECTION(bs), .SELF_CAL_OFFSET_COEFFICIENT(so),
        .SYSTEM_OFFSET_COEFFICIENT(sy), .CAL_ACTIVE(ca), .CAL_GAIN_LOAD(cl), .CAL_GAIN_VALUE(cv),
        .RESULT_VALID(rv), .RESULT_DATA(rd), .RESULT_READY(rr), .OUT_VALID(ov), .OUT_DATA(od),
        .OUT_READY(ordy), .SELF_CAL_GAIN_COEFFICIENT(coef));
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait for the write answer
    task wait_flag(output logic d, output logic p);
        int n;
        for (n = 0; n < 10 && !(wdone || wdrop); n++) @(negedge clk);
        if (n == 10) begin bad_count++; summarize(); end
        d = wdone;
        p = wdrop;
    endtask
    function automatic longint sat(longint v);
        return v > 64'sh7F_FFFF ? 64'sh7F_FFFF : (v < -64'sh80_0000 ? -64'sh80_0000 : v);
    endfunction
    // reference chain: self offset, rounded gain with 1.0 at 2^22, system offset
    function automatic logic [23:0] mdl(logic [23:0] x, logic [23:0] g);
        longint v = $signed(x);
        if (!bo) v = sat(v - $signed(so));
        if (!bg) v = sat((v * $signed(g) + 64'sh20_0000) >>> 22);
        if (!bs) v = sat(v - $signed(sy));
        return v[23:0];
    endfunction
    task t_rw(input logic [23:0] v);
        logic d, p;
        logic [23:0] r;
        host.wr24(v, 24);
        wait_flag(d, p);
        chk({22'h0, d, p}, 24'h00_0002);
        chk(coef, v);
        host.rd24(r);
        chk(r, v);
    endtask
    // a frame one bit short must leave the coefficient alone and raise no flag
    task automatic t_short;
        logic [23:0] old;
        logic f;
        old = coef;
        f = 1'b0;
        host.wr24(24'h12_3456, 23);
        repeat (6) begin
            @(negedge clk);
            if (wdone !== 1'b0 || wdrop !== 1'b0) f = 1'b1;
        end
        chk({23'h0, f}, 24'h00_0000);
        chk(coef, old);
    endtask
    task automatic t_cal(input logic [23:0] v);
        logic d, p;
        logic [23:0] old;
        old = coef;
        ca = 1;
        host.wr24(~old, 24);
        wait_flag(d, p);
        chk({22'h0, d, p}, 24'h00_0001);
        chk(coef, old);
        cl = 1;
        cv = v;
        @(negedge clk) cl = 0;
        chk(coef, v);
        ca = 0;
    endtask
    // mid-run reset: coefficient and streams return to their reset state
    task t_reset;
        rst_n = 0;
        repeat (2) @(negedge clk);
        rst_n = 1;
        chk(coef, GAIN_RESET);
        chk({22'h0, rr, ov}, 24'h00_0002);
    endtask
    task t_data(input logic [23:0] x, input logic [23:0] g, input logic [2:0] b);
        int n;
        {bs, bo, bg} = b;
        cl = 1;
        cv = g;
        @(negedge clk) begin cl = 0; rv = 1; rd = x; end
        @(negedge clk) rv = 0;
        for (n = 0; n < 20 && ov !== 1'b1; n++) @(negedge clk);
        if (n == 20) begin bad_count++; summarize(); end
        chk(od, mdl(x, g));
        @(negedge clk);
    endtask
    // fill with the output stalled until refused, then drain in order
    task automatic t_fifo;
        int n = 0, k = 0, g = 0;
        {bs, bo, bg} = 3'b111;
        ordy = 0;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            if (!rr) break;
            rv = 1;
            rd = n[23:0];
            n++;
        end
        rv = 0;
        // three pipeline stages fill before the stalled output blocks the buffer
        chk(n[23:0], 24'(FIFO_DEPTH + 3));
        ordy = 1;
        // the head word already stands on the output, so look before waiting
        for (g = 0; k < n && g < 200; g++) begin
            if (ov === 1'b1) begin chk(od, k[23:0]); k++; end
            @(negedge clk);
        end
        chk(k[23:0], n[23:0]);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1;
        chk(coef, GAIN_RESET);
        chk({23'h0, rr}, 24'h00_0001);
        t_rw(24'h80_0001);
        t_rw(24'h7F_FFFE);
        t_short();
        t_cal(24'h45_6789);
        t_data(24'h10_0000, 24'h40_0000, 3'b000);
        t_data(24'h30_0000, 24'h7F_FFFF, 3'b000);
        t_data(24'h20_0000, 24'hC0_0000, 3'b000);
        t_data(24'h12_3456, 24'h60_0000, 3'b001);
        t_data(24'h7F_FFF0, 24'h7F_FFFF, 3'b010);
        t_data(24'hF0_0000, 24'h50_0000, 3'b100);
        t_reset();
        t_fifo();
        summarize();
    end
endmodule
